// *** hdl/qcr_cfg_mem.sv ***
/*
 Shared constants of the queue configuration capture block, and the small
 per-queue setup memory that serial loading fills.
 Assumes a single clock; the read data are registered, one cycle of latency.
*/

package qcr_pkg;
    localparam int QCR_QW = 5;
    localparam int QCR_CW = 6;
    localparam int QCR_FW = 16;
    localparam int QCR_WORD_W = 3 * QCR_FW;
    localparam int QCR_QBITS_W = 72;
    localparam logic [11:0] QCR_HDR_BITS = 12'h013;
    localparam logic [6:0] QCR_QUEUE_BITS = 7'h48;
    localparam int QCR_DEPTH_LSB = 0;
    localparam int QCR_AE_LSB = 16;
    localparam int QCR_AF_LSB = 32;
    localparam int QCR_HDR_CNT_LSB = 0;
    localparam logic [QCR_CW-1:0] QCR_Q_ONE = 6'h01;
    localparam logic [QCR_CW-1:0] QCR_Q16 = 6'h10;
    localparam logic [QCR_CW-1:0] QCR_Q32 = 6'h20;
    localparam logic [QCR_FW-1:0] QCR_OFS_LOW = 16'h0008;
    localparam logic [QCR_FW-1:0] QCR_OFS_HIGH = 16'h0080;
    localparam logic [1:0] QCR_BUS_X36 = 2'h0;
    localparam logic [1:0] QCR_BUS_X18 = 2'h1;
    localparam logic [1:0] QCR_BUS_X9 = 2'h2;
    localparam logic [5:0] QCR_W36 = 6'h24;
    localparam logic [5:0] QCR_W18 = 6'h12;
    localparam logic [5:0] QCR_W9 = 6'h09;

    typedef enum logic [1:0] {
        QCR_SEL_WADDR = 2'b00,
        QCR_SEL_RADDR = 2'b01,
        QCR_SEL_16Q = 2'b10,
        QCR_SEL_32Q = 2'b11
    } qcr_sel_t;

    typedef enum logic [2:0] {
        QCR_ST_IDLE = 3'b000,
        QCR_ST_LOAD = 3'b001,
        QCR_ST_SERIAL = 3'b010,
        QCR_ST_DONE = 3'b011,
        QCR_ST_HOLD = 3'b100
    } qcr_state_t;
endpackage

`timescale 1ns/1ns

module qcr_cfg_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 48
) (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [DW-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem_r [DEPTH];

    // No reset on the array: contents are only read after a full serial load
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule

// *** hdl/qcr_top.sv ***
/*
 Master-reset and programming-mode capture for a multi-queue flow-control
 memory: strap latching, setup loading and completion signalling.
 Assumes all control pins are asynchronous to REF_CLK_I and that the serial
 clock is much slower than REF_CLK_I, so it can be sampled.
*/
`timescale 1ns/1ns

module qcr_top #(
    parameter logic [31:0] TOTAL_WORDS = 32'h00004000,
    parameter logic [15:0] LOAD_CYCLES = 16'h0040
) (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CONFIG_RESET_N_I,
    input wire logic [1:0] QUEUE_PROGRAM_SELECT_I,
    input wire logic DEFAULT_MODE_SELECT_I,
    input wire logic OFFSET_CHOICE_I,
    input wire logic PACKET_MODE_SELECT_I,
    input wire logic FLAG_BUS_STYLE_I,
    input wire logic [3:0] WIDTH_MATCH_SELECT_I,
    input wire logic MASTER_DEVICE_SELECT_I,
    input wire logic [2:0] DEVICE_POSITION_CODE_I,
    input wire logic [qcr_pkg::QCR_QW-1:0] WRITE_ADDR_I,
    input wire logic [qcr_pkg::QCR_QW-1:0] READ_ADDR_I,
    input wire logic SERIAL_CLK_I,
    input wire logic SERIAL_DATA_I,
    input wire logic SERIAL_ENABLE_IN_N_I,
    input wire logic QUEUE_WRITE_REQ_I,
    input wire logic QUEUE_READ_REQ_I,
    input wire logic [qcr_pkg::QCR_QW-1:0] QUEUE_INFO_SEL_I,
    output logic SERIAL_ENABLE_OUT_O,
    output logic CONFIG_DONE_O,
    output logic QUEUE_WRITE_EN_O,
    output logic QUEUE_READ_EN_O,
    output logic [qcr_pkg::QCR_CW-1:0] QUEUE_COUNT_O,
    output logic [qcr_pkg::QCR_FW-1:0] QUEUE_DEPTH_O,
    output logic [qcr_pkg::QCR_FW-1:0] ALMOST_EMPTY_OFFSET_O,
    output logic [qcr_pkg::QCR_FW-1:0] ALMOST_FULL_OFFSET_O,
    output logic [5:0] IN_WIDTH_O,
    output logic [5:0] OUT_WIDTH_O,
    output logic PACKET_MODE_O,
    output logic FLAG_BUS_STYLE_O,
    output logic MASTER_DEVICE_O,
    output logic [2:0] DEVICE_POSITION_O
);
    import qcr_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [5:0] bus_width(input logic [1:0] code);
        unique case (code)
            QCR_BUS_X18: bus_width = QCR_W18;
            QCR_BUS_X9: bus_width = QCR_W9;
            default: bus_width = QCR_W36;
        endcase
    endfunction

    function automatic logic [QCR_FW-1:0] even_depth(input logic [QCR_CW-1:0] cnt);
        logic [31:0] q;
        q = (cnt == '0) ? 32'h0 : TOTAL_WORDS / {26'h0, cnt};
        even_depth = q[QCR_FW-1:0];
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Reset, serial clock and serial enable: three stages, a change counts once stages two and three agree
    logic [2:0] rst_s_r, sclk_s_r, serial_enable_in_s_r;
    logic [1:0] sdat_s_r;
    logic rst_lvl_r, sclk_lvl_r, serial_enable_in_lvl_r;
    logic [18:0] strap_s1_r, strap_s2_r, strap_s3_r;
    logic [18:0] strap_pins;

    assign strap_pins = {QUEUE_PROGRAM_SELECT_I, DEFAULT_MODE_SELECT_I, OFFSET_CHOICE_I,
                         PACKET_MODE_SELECT_I, FLAG_BUS_STYLE_I, WIDTH_MATCH_SELECT_I,
                         MASTER_DEVICE_SELECT_I, DEVICE_POSITION_CODE_I, WRITE_ADDR_I[0],
                         READ_ADDR_I[0], 3'h0};

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            // Idle level of the pin is high; a low start would fake a rise
            rst_s_r <= 3'h7;
            sclk_s_r <= 3'h0;
            serial_enable_in_s_r <= 3'h7;
            sdat_s_r <= 2'h0;
            strap_s1_r <= '0;
            strap_s2_r <= '0;
            strap_s3_r <= '0;
        end else begin
            rst_s_r <= {rst_s_r[1:0], CONFIG_RESET_N_I};
            sclk_s_r <= {sclk_s_r[1:0], SERIAL_CLK_I};
            serial_enable_in_s_r <= {serial_enable_in_s_r[1:0], SERIAL_ENABLE_IN_N_I};
            sdat_s_r <= {sdat_s_r[0], SERIAL_DATA_I};
            strap_s1_r <= strap_pins;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
        end
    end

    // Address buses are wider than the strap vector carries; their own stages
    logic [QCR_QW-1:0] wa_s1_r, wa_s2_r, wa_s3_r, ra_s1_r, ra_s2_r, ra_s3_r;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wa_s1_r <= '0;
            wa_s2_r <= '0;
            wa_s3_r <= '0;
            ra_s1_r <= '0;
            ra_s2_r <= '0;
            ra_s3_r <= '0;
        end else begin
            wa_s1_r <= WRITE_ADDR_I;
            wa_s2_r <= wa_s1_r;
            wa_s3_r <= wa_s2_r;
            ra_s1_r <= READ_ADDR_I;
            ra_s2_r <= ra_s1_r;
            ra_s3_r <= ra_s2_r;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            rst_lvl_r <= 1'b1;
            sclk_lvl_r <= 1'b0;
            serial_enable_in_lvl_r <= 1'b1;
        end else begin
            if (rst_s_r[1] == rst_s_r[2]) begin
                rst_lvl_r <= rst_s_r[2];
            end
            if (sclk_s_r[1] == sclk_s_r[2]) begin
                sclk_lvl_r <= sclk_s_r[2];
            end
            if (serial_enable_in_s_r[1] == serial_enable_in_s_r[2]) begin
                serial_enable_in_lvl_r <= serial_enable_in_s_r[2];
            end
        end
    end

    logic cfg_rise, sclk_rise;
    assign cfg_rise = !rst_lvl_r && rst_s_r[1] && rst_s_r[2];
    assign sclk_rise = !sclk_lvl_r && sclk_s_r[1] && sclk_s_r[2];

    // ------------------------------------------------------------
    // Strap and mode capture
    // ------------------------------------------------------------
    logic [1:0] queue_program_select_r;
    logic dfm_r, ofs_r, pkt_r, fbs_r, master_device_select_r;
    logic [3:0] width_r;
    logic [2:0] pos_r;
    logic [QCR_QW-1:0] addr_cap_r;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            queue_program_select_r <= 2'h0;
            dfm_r <= 1'b0;
            ofs_r <= 1'b0;
            pkt_r <= 1'b0;
            fbs_r <= 1'b0;
            width_r <= 4'h0;
            master_device_select_r <= 1'b0;
            pos_r <= 3'h0;
            addr_cap_r <= '0;
        end else if (cfg_rise) begin
            {queue_program_select_r, dfm_r, ofs_r, pkt_r, fbs_r, width_r, master_device_select_r, pos_r} <= strap_s3_r[18:5];
            addr_cap_r <= strap_s3_r[17] ? ra_s3_r : wa_s3_r;
        end
    end

    assign PACKET_MODE_O = pkt_r;
    assign FLAG_BUS_STYLE_O = fbs_r;
    assign MASTER_DEVICE_O = master_device_select_r;
    assign DEVICE_POSITION_O = pos_r;
    assign IN_WIDTH_O = bus_width(width_r[1:0]);
    assign OUT_WIDTH_O = bus_width(width_r[3:2]);

    // ------------------------------------------------------------
    // Configuration sequencer
    // ------------------------------------------------------------
    qcr_state_t state_r;
    logic serial_r;
    logic [QCR_CW-1:0] qcount_r;
    logic [15:0] load_cnt_r;
    logic [11:0] hdr_cnt_r;
    logic [18:0] hdr_sh_r;
    logic [6:0] qbit_r;
    logic [QCR_QW-1:0] qidx_r;
    logic [QCR_QBITS_W-1:0] q_sh_r;
    logic mem_we_r;
    logic [QCR_WORD_W-1:0] mem_wd_r;
    logic [QCR_QW-1:0] mem_wa_r;
    logic [18:0] hdr_nxt;
    logic [QCR_QBITS_W-1:0] q_nxt;
    logic [QCR_CW-1:0] hdr_cnt_val;

    assign hdr_nxt = {sdat_s_r[1], hdr_sh_r[18:1]};
    assign q_nxt = {sdat_s_r[1], q_sh_r[QCR_QBITS_W-1:1]};
    assign hdr_cnt_val = {1'b0, hdr_nxt[QCR_HDR_CNT_LSB +: QCR_QW]} + QCR_Q_ONE;

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_r <= QCR_ST_IDLE;
            serial_r <= 1'b0;
            qcount_r <= '0;
            load_cnt_r <= 16'h0;
            hdr_cnt_r <= 12'h0;
            hdr_sh_r <= '0;
            qbit_r <= 7'h0;
            qidx_r <= '0;
            q_sh_r <= '0;
            mem_we_r <= 1'b0;
            mem_wd_r <= '0;
            mem_wa_r <= '0;
        end else if (!rst_lvl_r && !cfg_rise) begin
            // Held in master reset: state, counters and queue count cleared; shift registers and write data kept
            state_r <= QCR_ST_IDLE;
            serial_r <= 1'b0;
            qcount_r <= '0;
            load_cnt_r <= 16'h0;
            hdr_cnt_r <= 12'h0;
            qbit_r <= 7'h0;
            qidx_r <= '0;
            mem_we_r <= 1'b0;
        end else begin
            mem_we_r <= 1'b0;
            unique case (state_r)
                QCR_ST_IDLE: begin
                    if (cfg_rise) begin
                        load_cnt_r <= 16'h0;
                        serial_r <= !strap_s3_r[16];
                        if (strap_s3_r[16]) begin
                            state_r <= QCR_ST_LOAD;
                            unique case (qcr_sel_t'(strap_s3_r[18:17]))
                                QCR_SEL_16Q: qcount_r <= QCR_Q16;
                                QCR_SEL_32Q: qcount_r <= QCR_Q32;
                                QCR_SEL_RADDR: qcount_r <= {1'b0, ra_s3_r} + QCR_Q_ONE;
                                QCR_SEL_WADDR: qcount_r <= {1'b0, wa_s3_r} + QCR_Q_ONE;
                            endcase
                        end else if (strap_s3_r[18:17] == QCR_SEL_32Q) begin
                            state_r <= QCR_ST_SERIAL;
                        end else begin
                            // Reserved codes never complete, so access stays blocked
                            state_r <= QCR_ST_HOLD;
                        end
                    end
                end
                QCR_ST_LOAD: begin
                    load_cnt_r <= load_cnt_r + 16'h1;
                    if (load_cnt_r == LOAD_CYCLES - 16'h1) begin
                        state_r <= QCR_ST_DONE;
                    end
                end
                QCR_ST_SERIAL: begin
                    if (sclk_rise && !serial_enable_in_lvl_r) begin
                        if (hdr_cnt_r != QCR_HDR_BITS) begin
                            hdr_sh_r <= hdr_nxt;
                            hdr_cnt_r <= hdr_cnt_r + 12'h1;
                            if (hdr_cnt_r == QCR_HDR_BITS - 12'h1) begin
                                qcount_r <= hdr_cnt_val;
                            end
                        end else begin
                            q_sh_r <= q_nxt;
                            qbit_r <= qbit_r + 7'h1;
                            if (qbit_r == QCR_QUEUE_BITS - 7'h1) begin
                                qbit_r <= 7'h0;
                                mem_we_r <= 1'b1;
                                mem_wa_r <= qidx_r;
                                mem_wd_r <= q_nxt[QCR_WORD_W-1:0];
                                qidx_r <= qidx_r + 5'h1;
                                if ({1'b0, qidx_r} == qcount_r - QCR_Q_ONE) begin
                                    state_r <= QCR_ST_LOAD;
                                end
                            end
                        end
                    end
                end
                QCR_ST_DONE: state_r <= QCR_ST_DONE;
                QCR_ST_HOLD: state_r <= QCR_ST_HOLD;
                default: state_r <= QCR_ST_IDLE;
            endcase
        end
    end

    assign CONFIG_DONE_O = (state_r == QCR_ST_DONE);
    assign QUEUE_COUNT_O = qcount_r;
    assign QUEUE_WRITE_EN_O = QUEUE_WRITE_REQ_I && CONFIG_DONE_O;
    assign QUEUE_READ_EN_O = QUEUE_READ_REQ_I && CONFIG_DONE_O;

    // ------------------------------------------------------------
    // Completion indication
    // ------------------------------------------------------------
    // After completion the output follows the serial enable input
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            SERIAL_ENABLE_OUT_O <= 1'b1;
        end else begin
            SERIAL_ENABLE_OUT_O <= CONFIG_DONE_O ? serial_enable_in_lvl_r : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Per-queue setup readout
    // ------------------------------------------------------------
    logic [QCR_WORD_W-1:0] mem_rd;
    logic [QCR_FW-1:0] fixed_ofs;
    logic sel_ok;

    qcr_cfg_mem #(.DEPTH(32), .AW(QCR_QW), .DW(QCR_WORD_W)) u_mem (
        .clk_i(REF_CLK_I),
        .wr_en_i(mem_we_r),
        .wr_addr_i(mem_wa_r),
        .wr_data_i(mem_wd_r),
        .rd_addr_i(QUEUE_INFO_SEL_I),
        .rd_data_o(mem_rd)
    );

    assign fixed_ofs = ofs_r ? QCR_OFS_HIGH : QCR_OFS_LOW;
    assign sel_ok = CONFIG_DONE_O && ({1'b0, QUEUE_INFO_SEL_I} < qcount_r);

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            QUEUE_DEPTH_O <= '0;
            ALMOST_EMPTY_OFFSET_O <= '0;
            ALMOST_FULL_OFFSET_O <= '0;
        end else if (!sel_ok) begin
            QUEUE_DEPTH_O <= '0;
            ALMOST_EMPTY_OFFSET_O <= '0;
            ALMOST_FULL_OFFSET_O <= '0;
        end else if (serial_r) begin
            // Memory read lags the select by one cycle; hold the select steady
            QUEUE_DEPTH_O <= mem_rd[QCR_DEPTH_LSB +: QCR_FW];
            ALMOST_EMPTY_OFFSET_O <= mem_rd[QCR_AE_LSB +: QCR_FW];
            ALMOST_FULL_OFFSET_O <= mem_rd[QCR_AF_LSB +: QCR_FW];
        end else begin
            QUEUE_DEPTH_O <= even_depth(qcount_r);
            ALMOST_EMPTY_OFFSET_O <= fixed_ofs;
            ALMOST_FULL_OFFSET_O <= fixed_ofs;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    cfg_clear_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (!rst_lvl_r && !cfg_rise) |=> (state_r == QCR_ST_IDLE) && !CONFIG_DONE_O)
        else $error("setup not cleared during master reset");
    access_gate_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (QUEUE_WRITE_EN_O || QUEUE_READ_EN_O) |-> (state_r == QCR_ST_DONE))
        else $error("queue access before configuration done");
    mode_latch_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        cfg_rise |=> (queue_program_select_r == $past(strap_s3_r[18:17])) && (dfm_r == $past(strap_s3_r[16])))
        else $error("mode selects not latched on reset rise");
    load_time_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        $rose(CONFIG_DONE_O) |-> $past(state_r) == QCR_ST_LOAD
            && $past(load_cnt_r) == LOAD_CYCLES - 16'h1)
        else $error("configuration finished without load cycles");
    serial_enable_out_fall_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        !CONFIG_DONE_O |=> SERIAL_ENABLE_OUT_O)
        else $error("serial enable out low before completion");
    count_range_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CONFIG_DONE_O |-> qcount_r >= QCR_Q_ONE && qcount_r <= QCR_Q32
            && (!dfm_r || queue_program_select_r[1] == 1'b0 || qcount_r == QCR_Q16 || qcount_r == QCR_Q32))
        else $error("queue count out of range");
    fixed_ofs_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (sel_ok && !serial_r) |=> ALMOST_EMPTY_OFFSET_O == (ofs_r ? QCR_OFS_HIGH : QCR_OFS_LOW)
            && ALMOST_FULL_OFFSET_O == ALMOST_EMPTY_OFFSET_O)
        else $error("fixed offset wrong");
    strap_hold_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        !cfg_rise |=> $stable(width_r) && $stable(dfm_r) && $stable(queue_program_select_r) && $stable(pos_r))
        else $error("latched strap changed without master reset");
    sel_decode_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (cfg_rise && state_r == QCR_ST_IDLE && !strap_s3_r[16] && strap_s3_r[18:17] != 2'b11)
            |=> state_r == QCR_ST_HOLD ##1 !CONFIG_DONE_O)
        else $error("reserved select code did not stall");
    width_map_a: assert property (@(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (IN_WIDTH_O == QCR_W9 || IN_WIDTH_O == QCR_W18 || IN_WIDTH_O == QCR_W36)
            && (width_r[1:0] != QCR_BUS_X9 || IN_WIDTH_O == QCR_W9))
        else $error("port width decode wrong");
endmodule

// *** sim/qcr_host.sv ***
/*
 Host controller model: config reset, strap and serial programming pins.
 Assumes a free-running REF_CLK_I; every pin changes 5 or 6 ns after its rise.
*/
`timescale 1ns/1ns
module qcr_host (
    input wire logic clk_i,
    output logic cfg_rst_n_o,
    output logic [23:0] cfg_o,
    output logic sclk_o,
    output logic sdat_o,
    output logic serial_enable_in_n_o
);
    initial begin
        {cfg_rst_n_o, cfg_o} = 25'h1000000;
        {sclk_o, sdat_o, serial_enable_in_n_o} = 3'h1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    // Straps: sel, dfm, ofs, pkt, fm, bm[3:0], master_device_select, id[2:0], waddr, raddr
    task automatic reset_low(input logic [23:0] c);
        tick(1);
        cfg_rst_n_o = 1'b0;
        cfg_o = c;
        serial_enable_in_n_o = ~c[21];
        tick(6);
    endtask
    task automatic reset_high();
        cfg_rst_n_o = 1'b1;
        tick(5);
    endtask
    // Straps may wander once captured
    task automatic wiggle();
        cfg_o = ~cfg_o;
    endtask
    // One queue only: a longer stream would dominate the run time
    task automatic serial_load(input logic [47:0] q);
        logic [90:0] bits;
        bits = {24'h0, q, 19'h0};
        serial_enable_in_n_o = 1'b0;
        for (int i = 0; i < 91; i++) begin
            sdat_o = bits[i];
            tick(4);
            sclk_o = 1'b1;
            tick(4);
            sclk_o = 1'b0;
            sdat_o = ~bits[i]; // No stale data after hold
            tick(1);
        end
    endtask
endmodule

// *** sim/tb_queue_config_reset_capture.sv ***
/*
 Self-checking bench for the configuration capture block.
 Assumes the host model qcr_host; expected values are queued as notes.
*/
`timescale 1ns/1ns
module tb_queue_config_reset_capture;
    import qcr_pkg::*;
    typedef struct {int k; logic [15:0] v;} qcr_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wreq = 1'b1;
    logic rreq = 1'b1;
    logic [4:0] info = 5'h0;
    logic cfg_n, sclk, sdat, serial_enable_in_n, seo, done, wen, ren, pkt, fm, master_device_select;
    logic [23:0] c;
    logic [5:0] cnt, inw, outw;
    logic [15:0] depth, ae, af;
    logic [2:0] id;
    qcr_note_t notes[$];
    event look;
    int mismatches = 0;
    int samples_checked = 0;
    qcr_host host (.clk_i(clk), .cfg_rst_n_o(cfg_n), .cfg_o(c), .sclk_o(sclk),
        .sdat_o(sdat), .serial_enable_in_n_o(serial_enable_in_n));
    qcr_top #(.TOTAL_WORDS(32'h00004000), .LOAD_CYCLES(16'h0004)) uut (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .CONFIG_RESET_N_I(cfg_n),
        .QUEUE_PROGRAM_SELECT_I(c[23:22]), .DEFAULT_MODE_SELECT_I(c[21]),
        .OFFSET_CHOICE_I(c[20]), .PACKET_MODE_SELECT_I(c[19]), .FLAG_BUS_STYLE_I(c[18]),
        .WIDTH_MATCH_SELECT_I(c[17:14]), .MASTER_DEVICE_SELECT_I(c[13]),
        .DEVICE_POSITION_CODE_I(c[12:10]), .WRITE_ADDR_I(c[9:5]), .READ_ADDR_I(c[4:0]),
        .SERIAL_CLK_I(sclk), .SERIAL_DATA_I(sdat), .SERIAL_ENABLE_IN_N_I(serial_enable_in_n),
        .QUEUE_WRITE_REQ_I(wreq), .QUEUE_READ_REQ_I(rreq), .QUEUE_INFO_SEL_I(info),
        .SERIAL_ENABLE_OUT_O(seo), .CONFIG_DONE_O(done), .QUEUE_WRITE_EN_O(wen),
        .QUEUE_READ_EN_O(ren), .QUEUE_COUNT_O(cnt), .QUEUE_DEPTH_O(depth),
        .ALMOST_EMPTY_OFFSET_O(ae), .ALMOST_FULL_OFFSET_O(af), .IN_WIDTH_O(inw),
        .OUT_WIDTH_O(outw), .PACKET_MODE_O(pkt), .FLAG_BUS_STYLE_O(fm),
        .MASTER_DEVICE_O(master_device_select), .DEVICE_POSITION_O(id));
    initial forever #50 clk = ~clk;
    // ----------------------------------------
    // Result watcher
    // ----------------------------------------
    function automatic logic [15:0] actual(input int k);
        case (k)
            0: return {10'h0, cnt};
            1: return depth;
            2: return ae;
            3: return af;
            4: return {15'h0, seo};
            5: return {15'h0, done};
            6: return {14'h0, wen, ren};
            7: return {4'h0, inw, outw};
            default: return {10'h0, pkt, fm, master_device_select, id};
        endcase
    endfunction
    task automatic compare_field(input logic [15:0] e, input logic [15:0] a);
        samples_checked++;
        if (a !== e) begin
            mismatches++;
            $display("unexpected at %0t: exp %h got %h", $time, e, a);
        end
    endtask
    always @(look) begin
        qcr_note_t n;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            compare_field(n.v, actual(n.k));
        end
    end
    task automatic note(input int k, input logic [15:0] v);
        notes.push_back('{k, v});
    endtask
    task automatic fire();
        ->look;
        #1;
    endtask
    function automatic logic [5:0] wd(input logic [1:0] b);
        return (b == 2'h1) ? QCR_W18 : (b == 2'h2) ? QCR_W9 : QCR_W36;
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run is near 1250 cycles; sixteen times that is a hang
    initial begin
        #2000000;
        mismatches++;
        end_of_test();
    end
    // ----------------------------------------
    // Modes: default 00..11, serial, reserved
    // ----------------------------------------
    initial begin
        logic [23:0] s;
        logic [15:0] n;
        logic [47:0] q;
        void'($urandom(32'h6170));
        repeat (10) @(posedge clk);
        #5;
        rst = 1'b0;
        for (int m = 0; m < 6; m++) begin
            s = 24'($urandom);
            s[23:21] = (m < 4) ? {m[1:0], 1'b1} : {(m == 4) ? 2'b11 : 2'b01, 1'b0};
            host.reset_low(s);
            note(0, 16'h0000);
            note(5, 16'h0000);
            fire();
            host.reset_high();
            note(4, 16'h0001);
            note(6, 16'h0000);
            fire();
            case (m)
                0: n = 16'(s[9:5]) + 16'h1;
                1: n = 16'(s[4:0]) + 16'h1;
                2: n = 16'h0010;
                3: n = 16'h0020;
                default: n = 16'h0001;
            endcase
            q = {16'h0080 >> (4 * {3'h0, ~s[20]}), 16'h0080 >> (4 * {3'h0, ~s[20]}),
                16'(32'h00004000 / 32'(n))};
            if (m == 4) begin
                q = 48'({$urandom, $urandom});
                host.serial_load(q);
            end
            for (int i = 0; i < 300 && seo !== 1'b0; i++) host.tick(1);
            if (m == 5) begin
                note(4, 16'h0001);
                note(5, 16'h0000);
                note(6, 16'h0000);
            end else begin
                note(4, 16'h0000);
                note(5, 16'h0001);
                note(6, 16'h0003);
                note(0, n);
                note(1, q[15:0]);
                note(2, q[31:16]);
                note(3, q[47:32]);
                note(7, {4'h0, wd(s[15:14]), wd(s[17:16])});
                note(8, {10'h0, s[19:18], s[13:10]});
                fire();
                host.wiggle();
                info = 5'h1f;
                host.tick(6);
                note(0, n);
                note(1, (n > 16'h001f) ? q[15:0] : 16'h0000);
                note(5, 16'h0001);
                note(7, {4'h0, wd(s[15:14]), wd(s[17:16])});
                note(8, {10'h0, s[19:18], s[13:10]});
                info = 5'h0;
            end
            fire();
            $display("test %0d done", m);
        end
        end_of_test();
    end
endmodule
